// ==== core/tplc_pkg.sv ====
// Constants and types for the touch probe latch correction block
`default_nettype none
package tplc_pkg;
	localparam logic [15:0] IDX_CORR_ONE = 16'h3709;
	localparam logic [15:0] IDX_COMM_EXT3 = 16'h3724;
	localparam logic [15:0] IDX_CORR_TWO = 16'h3792;
	localparam logic [15:0] IDX_PROBE_EXT = 16'h4304;
	localparam int BIT_EDGE_SPLIT = 5;
	localparam int BIT_P1_ZSRC = 0;
	localparam int BIT_P1_FB = 1;
	localparam int BIT_P2_ZSRC = 8;
	localparam int BIT_P2_FB = 9;
	localparam logic [15:0] PROBE_EXT_MASK = 16'h0303;
	localparam logic [15:0] RST_CORR = 16'h0000;
	localparam logic [15:0] RST_COMM_EXT3 = 16'h0000;
	localparam logic [15:0] RST_PROBE_EXT = 16'h0000;
	localparam logic signed [15:0] CORR_MIN = -16'sd2000;
	localparam logic signed [15:0] CORR_MAX = 16'sd2000;
	localparam int CORR_UNIT_PS = 25000;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CYC_PER_UNIT = CORR_UNIT_PS / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		TPLC_IDLE = 2'b01,
		TPLC_WAIT = 2'b10
	} tplc_edge_st_t;
endpackage
`default_nettype wire

// ==== core/tplc_chan_if.sv ====
// Signals between probe control and one latch channel
`default_nettype none
interface tplc_chan_if;
	logic signed [15:0] corr_rise;
	logic signed [15:0] corr_fall;
	logic arm;
	logic trig;
	logic signed [31:0] pos;
	logic signed [31:0] res [2];
	logic [1:0] done;
	modport ctl (output corr_rise, corr_fall, arm, trig, pos,
		input res, done);
	modport chan (input corr_rise, corr_fall, arm, trig, pos,
		output res, done);
endinterface
`default_nettype wire

// ==== core/tplc_channel.sv ====
// One probe latch channel with per-edge delay correction
`default_nettype none
module tplc_channel (
	input wire logic clk,
	input wire logic rst_n,
	tplc_chan_if.chan ch
);
	logic trig_prev;
	logic signed [31:0] pos_prev;
	logic signed [31:0] vel;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_prev <= 1'b0;
			pos_prev <= 32'sh0;
		end else begin
			trig_prev <= ch.trig;
			pos_prev <= ch.pos;
		end
	end

	// Per-cycle speed, used to project back for positive corrections
	assign vel = ch.pos - pos_prev;

	for (genvar e = 0; e < 2; e++) begin : g_edge
		tplc_pkg::tplc_edge_st_t st, next_st;
		logic [15:0] cnt, next_cnt;
		logic signed [31:0] res, next_res;
		logic done, next_done;
		logic hit;
		logic signed [15:0] corr;

		// Trigger high means optocoupler on: rising edge
		assign hit = (e == 0) ? (ch.trig & ~trig_prev)
			: (~ch.trig & trig_prev);
		assign corr = (e == 0) ? ch.corr_rise : ch.corr_fall;

		always_comb begin
			next_st = st;
			next_cnt = cnt;
			next_res = res;
			next_done = 1'b0;
			case (st)
				tplc_pkg::TPLC_IDLE: begin
					if (ch.arm && hit) begin
						if (corr < 0) begin
							// Late instant: wait before sampling
							next_cnt = 16'(-32'(corr)
								* tplc_pkg::CYC_PER_UNIT);
							next_st = tplc_pkg::TPLC_WAIT;
						end else begin
							// Early instant: the past cannot be sampled,
							// so extrapolate with current speed
							next_res = ch.pos - 32'(vel * 32'(corr)
								* tplc_pkg::CYC_PER_UNIT);
							next_done = 1'b1;
						end
					end
				end
				tplc_pkg::TPLC_WAIT: begin
					if (!ch.arm) begin
						next_st = tplc_pkg::TPLC_IDLE;
					end else if (cnt <= 16'h0001) begin
						next_res = ch.pos;
						next_done = 1'b1;
						next_st = tplc_pkg::TPLC_IDLE;
					end else begin
						next_cnt = cnt - 16'h0001;
					end
				end
				default: next_st = tplc_pkg::TPLC_IDLE;
			endcase
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				st <= tplc_pkg::TPLC_IDLE;
				cnt <= 16'h0000;
				res <= 32'sh0;
				done <= 1'b0;
			end else begin
				st <= next_st;
				cnt <= next_cnt;
				res <= next_res;
				done <= next_done;
			end
		end

		assign ch.res[e] = res;
		assign ch.done[e] = done;
	end
endmodule
`default_nettype wire

// ==== core/tplc_top.sv ====
// Touch probe latch delay correction and scale Z source selection
// Operation
// - First correction: signed 16-bit, 25 ns units, -2000..2000, used for latching
// - Split bit 5 clear: first correction serves rising and falling edges
// - Split bit set: first for rising, second for falling edges
// - Second correction: same format, ignored while split bit is clear
// - Optocoupler on is rising edge; off is falling edge
// - AB scale: differing probe Z-source bits on activation raise the fault
// - AB scale, both Z bits set: both trigger selects must be 1
// - Homing start with any Z-source bit set raises the fault
// - Scale feedback stored means results are in scale pulse units
// - Bit 0 picks probe 1 Z source, only under semi-closed control
// - Bit 8 picks probe 2 Z source, only under semi-closed control
// - Bits 1 and 9 pick stored feedback source, semi-closed only
// - Configuration is taken only on start bit rising from 0 to 1
`default_nettype none
module tplc_top (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic OBJ_WR,
	input wire logic OBJ_RD,
	input wire logic [15:0] OBJ_INDEX,
	input wire logic [15:0] OBJ_WDATA,
	output logic [15:0] OBJ_RDATA,
	output logic OBJ_ACK,
	output logic OBJ_NAK,
	input wire logic [1:0] PROBE_START,
	input wire logic PROBE_ONE_TRIGGER_SELECT,
	input wire logic PROBE_TWO_TRIGGER_SELECT,
	input wire logic [1:0] EXT_TRIG,
	input wire logic ENC_Z,
	input wire logic SCALE_Z,
	input wire logic signed [31:0] ENC_POS,
	input wire logic signed [31:0] SCALE_POS,
	input wire logic SEMI_CLOSED,
	input wire logic SCALE_AB_PHASE,
	input wire logic HOMING_START,
	input wire logic FAULT_CLR,
	output logic signed [31:0] PROBE1_RISE_POS,
	output logic signed [31:0] PROBE1_FALL_POS,
	output logic signed [31:0] PROBE2_RISE_POS,
	output logic signed [31:0] PROBE2_FALL_POS,
	output logic [1:0] PROBE_RISE_DONE,
	output logic [1:0] PROBE_FALL_DONE,
	output logic [1:0] PROBE_EXT_UNITS,
	output logic COMMAND_ERROR_FAULT_TWO
);
	logic [15:0] corr_one, next_corr_one;
	logic [15:0] corr_two, next_corr_two;
	logic [15:0] comm_ext3, next_comm_ext3;
	logic [15:0] probe_ext, next_probe_ext;
	logic [15:0] rdata, next_rdata;
	logic ack, next_ack;
	logic nak, next_nak;
	logic fault, next_fault;
	logic [1:0] start_prev;
	logic [1:0] start_rise;
	logic [1:0] trig_sel;
	logic act_err;
	logic wr_in_range;

	assign trig_sel = {PROBE_TWO_TRIGGER_SELECT, PROBE_ONE_TRIGGER_SELECT};
	assign start_rise = PROBE_START & ~start_prev;
	assign wr_in_range = ($signed(OBJ_WDATA) >= tplc_pkg::CORR_MIN)
		&& ($signed(OBJ_WDATA) <= tplc_pkg::CORR_MAX);

	// Out-of-range corrections are refused so the old value stays usable
	always_comb begin
		next_corr_one = corr_one;
		next_corr_two = corr_two;
		next_comm_ext3 = comm_ext3;
		next_probe_ext = probe_ext;
		next_rdata = rdata;
		next_ack = 1'b0;
		next_nak = 1'b0;
		if (OBJ_WR) begin
			next_ack = 1'b1;
			case (OBJ_INDEX)
				tplc_pkg::IDX_CORR_ONE: begin
					if (wr_in_range) begin
						next_corr_one = OBJ_WDATA;
					end else begin
						next_ack = 1'b0;
						next_nak = 1'b1;
					end
				end
				tplc_pkg::IDX_CORR_TWO: begin
					if (wr_in_range) begin
						next_corr_two = OBJ_WDATA;
					end else begin
						next_ack = 1'b0;
						next_nak = 1'b1;
					end
				end
				tplc_pkg::IDX_COMM_EXT3: next_comm_ext3 = OBJ_WDATA;
				tplc_pkg::IDX_PROBE_EXT: begin
					next_probe_ext = OBJ_WDATA & tplc_pkg::PROBE_EXT_MASK;
				end
				default: begin
					next_ack = 1'b0;
					next_nak = 1'b1;
				end
			endcase
		end else if (OBJ_RD) begin
			next_ack = 1'b1;
			case (OBJ_INDEX)
				tplc_pkg::IDX_CORR_ONE: next_rdata = corr_one;
				tplc_pkg::IDX_CORR_TWO: next_rdata = corr_two;
				tplc_pkg::IDX_COMM_EXT3: next_rdata = comm_ext3;
				tplc_pkg::IDX_PROBE_EXT: next_rdata = probe_ext;
				default: begin
					next_rdata = 16'h0000;
					next_ack = 1'b0;
					next_nak = 1'b1;
				end
			endcase
		end
	end

	// Activation checks against an AB-phase scale
	always_comb begin
		act_err = 1'b0;
		if (SCALE_AB_PHASE) begin
			if (probe_ext[tplc_pkg::BIT_P1_ZSRC]
				!= probe_ext[tplc_pkg::BIT_P2_ZSRC]) begin
				act_err = 1'b1;
			end else if (probe_ext[tplc_pkg::BIT_P1_ZSRC]
				&& trig_sel != 2'h3) begin
				act_err = 1'b1;
			end
		end
	end

	// A new error wins over a clear in the same cycle
	always_comb begin
		next_fault = fault & ~FAULT_CLR;
		if (|start_rise && act_err) begin
			next_fault = 1'b1;
		end
		if (HOMING_START && (probe_ext[tplc_pkg::BIT_P1_ZSRC]
			|| probe_ext[tplc_pkg::BIT_P2_ZSRC])) begin
			next_fault = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			corr_one <= tplc_pkg::RST_CORR;
			corr_two <= tplc_pkg::RST_CORR;
			comm_ext3 <= tplc_pkg::RST_COMM_EXT3;
			probe_ext <= tplc_pkg::RST_PROBE_EXT;
			rdata <= 16'h0000;
			ack <= 1'b0;
			nak <= 1'b0;
			fault <= 1'b0;
			start_prev <= 2'h0;
		end else begin
			corr_one <= next_corr_one;
			corr_two <= next_corr_two;
			comm_ext3 <= next_comm_ext3;
			probe_ext <= next_probe_ext;
			rdata <= next_rdata;
			ack <= next_ack;
			nak <= next_nak;
			fault <= next_fault;
			start_prev <= PROBE_START;
		end
	end

	assign OBJ_RDATA = rdata;
	assign OBJ_ACK = ack;
	assign OBJ_NAK = nak;
	assign COMMAND_ERROR_FAULT_TWO = fault;

	for (genvar p = 0; p < 2; p++) begin : g_probe
		localparam int ZBIT = (p == 0) ? tplc_pkg::BIT_P1_ZSRC
			: tplc_pkg::BIT_P2_ZSRC;
		localparam int FBIT = (p == 0) ? tplc_pkg::BIT_P1_FB
			: tplc_pkg::BIT_P2_FB;
		tplc_chan_if cif ();
		logic arm, next_arm;
		logic [15:0] c_rise, next_c_rise;
		logic [15:0] c_fall, next_c_fall;
		logic lt, next_lt;
		logic zsel, next_zsel;
		logic fb, next_fb;
		logic units, next_units;

		// Settings are frozen while started; changes need a restart
		always_comb begin
			next_c_rise = c_rise;
			next_c_fall = c_fall;
			next_lt = lt;
			next_zsel = zsel;
			next_fb = fb;
			next_arm = PROBE_START[p] & arm;
			if (start_rise[p]) begin
				next_arm = ~act_err;
				next_c_rise = corr_one;
				next_c_fall = comm_ext3[tplc_pkg::BIT_EDGE_SPLIT]
					? corr_two : corr_one;
				next_lt = trig_sel[p];
				next_zsel = probe_ext[ZBIT];
				next_fb = probe_ext[FBIT];
			end
			next_units = fb & SEMI_CLOSED;
		end

		always_ff @(posedge SYS_CLK or negedge RSTN) begin
			if (!RSTN) begin
				arm <= 1'b0;
				c_rise <= tplc_pkg::RST_CORR;
				c_fall <= tplc_pkg::RST_CORR;
				lt <= 1'b0;
				zsel <= 1'b0;
				fb <= 1'b0;
				units <= 1'b0;
			end else begin
				arm <= next_arm;
				c_rise <= next_c_rise;
				c_fall <= next_c_fall;
				lt <= next_lt;
				zsel <= next_zsel;
				fb <= next_fb;
				units <= next_units;
			end
		end

		assign cif.arm = arm;
		assign cif.corr_rise = c_rise;
		assign cif.corr_fall = c_fall;
		// Scale sources apply only while semi-closed control is active
		assign cif.trig = lt ? ((zsel && SEMI_CLOSED) ? SCALE_Z : ENC_Z)
			: EXT_TRIG[p];
		assign cif.pos = (fb && SEMI_CLOSED) ? SCALE_POS : ENC_POS;

		tplc_channel u_chan (
			.clk(SYS_CLK),
			.rst_n(RSTN),
			.ch(cif.chan)
		);

		assign PROBE_RISE_DONE[p] = cif.done[0];
		assign PROBE_FALL_DONE[p] = cif.done[1];
		assign PROBE_EXT_UNITS[p] = units;
	end

	assign PROBE1_RISE_POS = g_probe[0].cif.res[0];
	assign PROBE1_FALL_POS = g_probe[0].cif.res[1];
	assign PROBE2_RISE_POS = g_probe[1].cif.res[0];
	assign PROBE2_FALL_POS = g_probe[1].cif.res[1];
endmodule
`default_nettype wire

// ==== tb/tplc_monitor.sv ====
// Port checker for the probe latch block
`default_nettype none
module tplc_monitor (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic OBJ_WR,
	input wire logic OBJ_RD,
	input wire logic [15:0] OBJ_INDEX,
	input wire logic [15:0] OBJ_WDATA,
	input wire logic [15:0] OBJ_RDATA,
	input wire logic OBJ_ACK,
	input wire logic OBJ_NAK,
	input wire logic [1:0] PROBE_START,
	input wire logic HOMING_START,
	input wire logic FAULT_CLR,
	input wire logic SEMI_CLOSED,
	input wire logic signed [31:0] PROBE1_RISE_POS,
	input wire logic [1:0] PROBE_RISE_DONE,
	input wire logic [1:0] PROBE_EXT_UNITS,
	input wire logic COMMAND_ERROR_FAULT_TWO
);
	logic req, big, unk, st_rise;
	logic [1:0] st_q;
	assign req = OBJ_WR | OBJ_RD;
	assign st_rise = |(PROBE_START & ~st_q);
	assign unk = !(OBJ_INDEX inside {tplc_pkg::IDX_CORR_ONE,
		tplc_pkg::IDX_COMM_EXT3, tplc_pkg::IDX_CORR_TWO,
		tplc_pkg::IDX_PROBE_EXT});
	assign big = (OBJ_INDEX == tplc_pkg::IDX_CORR_ONE ||
		OBJ_INDEX == tplc_pkg::IDX_CORR_TWO) &&
		($signed(OBJ_WDATA) > 2000 || $signed(OBJ_WDATA) < -2000);
	// Previous start bits, so a start edge is seen as the design sees it
	always_ff @(posedge SYS_CLK or negedge RSTN)
		if (!RSTN)
			st_q <= 2'b00;
		else
			st_q <= PROBE_START;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	sequence unk_read;
		OBJ_RD && !OBJ_WR && unk ##1 OBJ_NAK;
	endsequence
	ack_once_a: assert property (req |=> OBJ_ACK ^ OBJ_NAK)
		else $error("access without single answer");
	quiet_bus_a: assert property (!req |=> !(OBJ_ACK | OBJ_NAK))
		else $error("answer without access");
	range_nak_a: assert property (OBJ_WR && big |=> OBJ_NAK)
		else $error("out of range correction taken");
	unk_zero_a: assert property (unk_read |-> OBJ_RDATA == 16'h0000)
		else $error("unknown read gave data");
	fault_hold_a: assert property (
		COMMAND_ERROR_FAULT_TWO && !FAULT_CLR |=> COMMAND_ERROR_FAULT_TWO)
		else $error("fault dropped without clear");
	fault_cause_a: assert property ($rose(COMMAND_ERROR_FAULT_TWO)
		|-> $past(HOMING_START) || $past(st_rise))
		else $error("fault without start or homing");
	pulse_once_a: assert property (
		PROBE_RISE_DONE[0] |=> !PROBE_RISE_DONE[0])
		else $error("done pulse too long");
	hold_pos_a: assert property (
		!PROBE_RISE_DONE[0] |-> $stable(PROBE1_RISE_POS))
		else $error("result moved without done");
	units_a: assert property (
		PROBE_EXT_UNITS[0] |-> $past(SEMI_CLOSED))
		else $error("scale units outside semi-closed");
endmodule
bind tplc_top tplc_monitor u_tplc_monitor (.*);
`default_nettype wire

// ==== tb/tplc_master.sv ====
// Fieldbus master model writing and reading configuration objects
`default_nettype none
module tplc_master (
	input wire logic clk,
	input wire logic ack,
	input wire logic nak,
	output logic wr,
	output logic rd,
	output logic [15:0] idx,
	output logic [15:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Scale monitor and scale latch enables are taken as already set
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		idx = 16'h0000;
		wdata = 16'h0000;
	end
	// Strobe is a one-cycle pulse; a held strobe would repeat the access
	task automatic access(input logic w, input logic [15:0] i,
		input logic [15:0] d, output logic n, output logic ok);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		idx <= i;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		ok = 1'b0;
		n = 1'b0;
		for (int k = 0; k < 4 && ok !== 1'b1; k++) begin
			#1;
			ok = ack | nak;
			n = nak;
			if (ok !== 1'b1)
				@(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tplc_top_bench.sv ====
// Self-checking bench for the probe latch block
`default_nettype none
module tplc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] IXS [4] = '{tplc_pkg::IDX_CORR_ONE,
		tplc_pkg::IDX_COMM_EXT3, tplc_pkg::IDX_CORR_TWO,
		tplc_pkg::IDX_PROBE_EXT};
	logic clk, rstn, wr, rd, ack, nak, ts1, ts2, semi, ab, hom, fclr, flt;
	logic ez, sz;
	logic [15:0] idx, wd, rdat;
	logic [1:0] st, trig, rdn, fdn, unit;
	logic signed [31:0] epos, spos, p1r, p1f, p2r, p2f;
	int errors, checks_done;
	tplc_top u_tplc_top (.SYS_CLK(clk), .RSTN(rstn), .OBJ_WR(wr),
		.OBJ_RD(rd), .OBJ_INDEX(idx), .OBJ_WDATA(wd), .OBJ_RDATA(rdat),
		.OBJ_ACK(ack), .OBJ_NAK(nak), .PROBE_START(st),
		.PROBE_ONE_TRIGGER_SELECT(ts1), .PROBE_TWO_TRIGGER_SELECT(ts2),
		.EXT_TRIG(trig), .ENC_Z(ez), .SCALE_Z(sz), .ENC_POS(epos),
		.SCALE_POS(spos), .SEMI_CLOSED(semi), .SCALE_AB_PHASE(ab),
		.HOMING_START(hom), .FAULT_CLR(fclr), .PROBE1_RISE_POS(p1r),
		.PROBE1_FALL_POS(p1f), .PROBE2_RISE_POS(p2r), .PROBE2_FALL_POS(p2f),
		.PROBE_RISE_DONE(rdn), .PROBE_FALL_DONE(fdn),
		.PROBE_EXT_UNITS(unit), .COMMAND_ERROR_FAULT_TWO(flt));
	tplc_master u_tplc_master (.clk(clk), .ack(ack), .nak(nak), .wr(wr),
		.rd(rd), .idx(idx), .wdata(wd));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		epos <= epos + 10;
		spos <= spos + 10;
	end
	task automatic summarize;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic obj(input logic w, input logic [15:0] i, d,
		output logic n);
		logic ok;
		u_tplc_master.access(w, i, d, n, ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t no answer", $time);
			summarize();
		end
	endtask
	task automatic rdchk(input logic [15:0] i, input logic [16:0] e);
		logic n;
		obj(1'b0, i, 16'h0000, n);
		cmp({n, rdat}, e);
	endtask
	task automatic restart;
		@(posedge clk);
		st <= 2'b00;
		@(posedge clk);
		st <= 2'b01;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic clr;
		@(posedge clk);
		fclr <= 1'b1;
		@(posedge clk);
		fclr <= 1'b0;
		@(posedge clk);
		#1;
		cmp(flt, 1'b0);
	endtask
	task automatic late(input int n);
		if (n >= 20) begin
			errors++;
			$display("[FAIL] %0t no latch result", $time);
			summarize();
		end
	endtask
	// Speed is 10 per cycle, so the expected result follows from epos
	task automatic trg(input logic lv, input int en, input int off);
		int n;
		n = 0;
		@(posedge clk);
		trig <= {1'b0, lv};
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((lv ? rdn[0] : fdn[0]) !== 1'b1 && n < 20);
		late(n);
		cmp(n, en);
		cmp(lv ? p1r : p1f, epos - off);
	endtask
	// Z-phase latch on both probes; probe 1 stores the scale position
	// unless encoder Z is in use, which only happens outside semi-closed
	task automatic zed(input logic enc, lv, input int en, off);
		int n;
		n = 0;
		@(posedge clk);
		if (enc)
			ez <= lv;
		else
			sz <= lv;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((lv ? rdn : fdn) !== 2'b11 && n < 20);
		late(n);
		cmp(n, en);
		cmp(lv ? p1r : p1f, (enc ? epos : spos) - off);
		cmp(lv ? p2r : p2f, epos - off);
	endtask
	task automatic t_regs;
		logic n;
		for (int k = 0; k < 4; k++)
			rdchk(IXS[k], 17'h00000);
		obj(1'b1, tplc_pkg::IDX_CORR_ONE, 16'h07d0, n);
		obj(1'b1, tplc_pkg::IDX_CORR_ONE, 16'h07d1, n);
		cmp(n, 1'b1);
		rdchk(tplc_pkg::IDX_CORR_ONE, 17'h007d0);
		obj(1'b1, tplc_pkg::IDX_CORR_TWO, 16'hf830, n);
		cmp(n, 1'b0);
		obj(1'b1, tplc_pkg::IDX_CORR_TWO, 16'hf82f, n);
		rdchk(tplc_pkg::IDX_CORR_TWO, 17'h0f830);
		obj(1'b1, tplc_pkg::IDX_PROBE_EXT, 16'hffff, n);
		rdchk(tplc_pkg::IDX_PROBE_EXT, 17'h00303);
		rdchk(16'h1234, 17'h10000);
	endtask
	task automatic t_latch;
		logic n;
		obj(1'b1, tplc_pkg::IDX_CORR_ONE, 16'h0002, n);
		obj(1'b1, tplc_pkg::IDX_CORR_TWO, 16'hffff, n);
		restart();
		trg(1'b1, 1, 110);
		trg(1'b0, 1, 110);
		obj(1'b1, tplc_pkg::IDX_COMM_EXT3, 16'h0020, n);
		trg(1'b1, 1, 110);
		trg(1'b0, 1, 110);
		restart();
		trg(1'b1, 1, 110);
		trg(1'b0, 6, 10);
	endtask
	task automatic t_fault;
		logic n;
		@(posedge clk);
		ab <= 1'b1;
		obj(1'b1, tplc_pkg::IDX_PROBE_EXT, 16'h0001, n);
		restart();
		cmp(flt, 1'b1);
		clr();
		obj(1'b1, tplc_pkg::IDX_PROBE_EXT, 16'h0101, n);
		restart();
		cmp(flt, 1'b1);
		clr();
		@(posedge clk);
		ts1 <= 1'b1;
		ts2 <= 1'b1;
		restart();
		cmp(flt, 1'b0);
		@(posedge clk);
		hom <= 1'b1;
		@(posedge clk);
		hom <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp(flt, 1'b1);
		clr();
	endtask
	task automatic t_units;
		logic n;
		@(posedge clk);
		ab <= 1'b0;
		semi <= 1'b1;
		obj(1'b1, tplc_pkg::IDX_PROBE_EXT, 16'h0002, n);
		restart();
		cmp(unit, 2'b01);
		@(posedge clk);
		semi <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp(unit, 2'b00);
	endtask
	task automatic t_zsrc;
		logic n;
		logic [1:0] seen;
		@(posedge clk);
		semi <= 1'b1;
		obj(1'b1, tplc_pkg::IDX_PROBE_EXT, 16'h0103, n);
		@(posedge clk);
		st <= 2'b00;
		@(posedge clk);
		st <= 2'b11;
		repeat (3) @(posedge clk);
		// Encoder Z must not latch while both probes pick the scale
		ez <= 1'b1;
		seen = 2'b00;
		repeat (4) begin
			@(posedge clk);
			ez <= 1'b0;
			#1;
			seen = seen | rdn | fdn;
		end
		cmp(seen, 2'b00);
		zed(1'b0, 1'b1, 1, 110);
		zed(1'b0, 1'b0, 6, 10);
		@(posedge clk);
		semi <= 1'b0;
		zed(1'b1, 1'b1, 1, 110);
		zed(1'b1, 1'b0, 6, 10);
	endtask
	initial begin
		{clk, rstn, ts1, ts2, semi, ab, hom, fclr, ez, sz} = 10'h000;
		st = 2'b00;
		trig = 2'b00;
		epos = 0;
		spos = 32'h00010000;
		errors = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_latch();
		t_fault();
		t_units();
		t_zsrc();
		summarize();
	end
endmodule
`default_nettype wire
